//--- gtu_defs.svh
// Constants for the general purpose timer unit
`ifndef GTU_DEFS_SVH
`define GTU_DEFS_SVH
// Contract
// - Five 16-bit timers: three in module one, two plus capture/reload in two.
// - Each auxiliary timer runs alone or counts latch events of the core timer in its module.
// - Module one timers each select timer, gated timer or counter mode.
// - Timer mode counts prescaled clocks; counter mode counts input pin events.
// - Gated mode counts prescaled clocks only while the gate pin level enables it.
// - Module one timer and gated modes count at most once per eight clocks.
// - Direction set by software bit, optionally flipped by the direction pin.
// - Core timer one toggles its latch on each wrap; latch may drive its pin.
// - Core one latch can clock both module one auxiliary timers.
// - Auxiliary timer used as capture or reload register stops counting.
// - Capture role copies core one value on selected edge of its pin.
// - Reload role loads core one on pin edge or selected latch transition.
// - Two auxiliaries reloading on opposite latch edges give hands-free PWM.
// - Module two counts prescaled clocks at most every four clocks, or pin events.
// - Core timer two toggles its latch on each wrap; clocks aux or drives pin.
// - Optionally each core two wrap reloads it from capture/reload register.
// - Capture pin edge stores aux second value; optionally clears that timer.
// - Each timer and capture register has request flag, enable, 16-level priority.

`define GTU_NUM_TIMERS      5
`define GTU_NUM_SRC         6
`define GTU_NUM_PINS        11
`define GTU_AUX_LOWER       0
`define GTU_CORE_ONE        1
`define GTU_AUX_UPPER       2
`define GTU_AUX_SECOND      3
`define GTU_CORE_SECOND     4
`define GTU_CAPTURE_RELOAD_REGISTER          5

`define GTU_ADDR_CTRL_BASE  8'h00
`define GTU_ADDR_COUNT_BASE 8'h20
`define GTU_ADDR_CAPTURE_RELOAD_REGISTER_CTL 8'h14
`define GTU_ADDR_CAPTURE_RELOAD_REGISTER     8'h34

`define GTU_CTRL_MASK       32'h003fffff
`define GTU_CTRL_RESET      32'h00000000
`define GTU_COUNT_RESET     16'h0000
`define GTU_REQ_BIT         21
`define GTU_EN_BIT          20

`define GTU_REF_CLK_MHZ     25
`define GTU_ONE_MIN_NS      320
`define GTU_TWO_MIN_NS      160
`define GTU_ONE_MIN_CYC     11'((`GTU_ONE_MIN_NS * `GTU_REF_CLK_MHZ) / 1000)
`define GTU_TWO_MIN_CYC     11'((`GTU_TWO_MIN_NS * `GTU_REF_CLK_MHZ) / 1000)
`define GTU_DIV_W           11

`endif

//--- gtu_pkg.sv
// Types and helpers for the general purpose timer unit
package gtu_pkg;

  typedef enum logic [1:0] {
    GTU_TIMER   = 2'h0,
    GTU_GATED   = 2'h1,
    GTU_COUNTER = 2'h3,
    GTU_ROLE    = 2'h2
  } gtu_mode_t;

  typedef struct packed {
    logic [9:0] rsv;
    logic       req;
    logic       en;
    logic [3:0] prio;
    logic       opt;
    logic       latch_trig;
    logic       reload_role;
    logic       chain;
    logic       pin_out;
    logic       ext_dir;
    logic       down;
    logic       run;
    logic [1:0] edge_sel;
    logic       gate_high;
    gtu_mode_t  mode;
    logic [2:0] prescale;
  } gtu_ctrl_t;

  typedef struct packed {
    logic       capture_trigger_pin;
    logic [4:0] timer_direction_pin;
    logic [4:0] timer_gate_clock_pin;
  } gtu_pins_t;

  function automatic logic gtu_edge_hit(input logic [1:0] sel, input logic rise,
                                        input logic fall);
    return (sel[0] & rise) | (sel[1] & fall);
  endfunction : gtu_edge_hit

  function automatic logic gtu_pre_tick(input logic [10:0] div, input logic [10:0] base,
                                        input logic [2:0] ps);
    logic [10:0] mask;
    mask = (base << ps) - 11'h001;
    return (div & mask) == 11'h000;
  endfunction : gtu_pre_tick

endpackage : gtu_pkg

//--- gtu_sync.sv
// Three-stage pin synchroniser with edge detection
`timescale 1ns/1ps
`include "gtu_defs.svh"
module gtu_sync (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic [`GTU_NUM_PINS-1:0] pin_async,
  output logic      [`GTU_NUM_PINS-1:0] level,
  output logic      [`GTU_NUM_PINS-1:0] rise,
  output logic      [`GTU_NUM_PINS-1:0] fall
);
  logic [`GTU_NUM_PINS-1:0] s1;
  logic [`GTU_NUM_PINS-1:0] s2;
  logic [`GTU_NUM_PINS-1:0] s3;
  logic [`GTU_NUM_PINS-1:0] next_level;

  always_ff @(posedge mclk) begin
    s1 <= pin_async;
    s2 <= s1;
    s3 <= s2;
  end

  // Accept a change once stages two and three agree
  assign next_level = ~(s2 ^ s3) & s3 | (s2 ^ s3) & level;

  always_ff @(posedge mclk) begin
    if (rst) begin
      level <= '0;
      rise  <= '0;
      fall  <= '0;
    end else begin
      level <= next_level;
      rise  <= next_level & ~level;
      fall  <= ~next_level & level;
    end
  end
endmodule : gtu_sync

//--- gtu_timer.sv
// One 16-bit up/down timer
`timescale 1ns/1ps
`include "gtu_defs.svh"
module gtu_timer (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        down,
  input  wire logic        load,
  input  wire logic [15:0] load_value,
  output logic      [15:0] count,
  output logic             wrap
);
  // Wrap does not depend on load, so reload on a wrap stays loop free
  assign wrap = tick & (down ? (count == 16'h0000) : (count == 16'hffff));

  always_ff @(posedge mclk) begin
    if (rst) begin
      count <= `GTU_COUNT_RESET;
    end else if (load) begin
      count <= load_value;
    end else if (tick) begin
      count <= down ? count - 16'h0001 : count + 16'h0001;
    end
  end
endmodule : gtu_timer

//--- gtu_unit.sv
// General purpose timer unit top with AHB-Lite register slave
`timescale 1ns/1ps
`include "gtu_defs.svh"
module gtu_unit (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic      [31:0]       hrdata,
  output logic                   hresp,
  input  wire gtu_pkg::gtu_pins_t pins,
  output logic                   core_one_toggle_pin,
  output logic                   core_two_toggle_pin,
  output logic      [5:0]        irq_pending
);

  // Bus state
  logic                     ap_take;
  logic                     wr_pend;
  logic [7:0]               wr_addr;
  logic                     addr_ok;

  // Registers
  gtu_pkg::gtu_ctrl_t       ctrl [`GTU_NUM_SRC];
  logic [15:0]              capture_reload_register;
  logic [`GTU_DIV_W-1:0]    div;
  logic                     core_one_toggle_latch;
  logic                     core_two_toggle_latch;

  // Synchronised pins
  logic [`GTU_NUM_PINS-1:0] pin_lvl;
  logic [`GTU_NUM_PINS-1:0] pin_rise;
  logic [`GTU_NUM_PINS-1:0] pin_fall;

  // Timer connections
  logic [15:0]              cnt      [`GTU_NUM_TIMERS];
  logic [15:0]              load_val [`GTU_NUM_TIMERS];
  logic [`GTU_NUM_TIMERS-1:0] tick;
  logic [`GTU_NUM_TIMERS-1:0] down;
  logic [`GTU_NUM_TIMERS-1:0] load;
  logic [`GTU_NUM_TIMERS-1:0] wrap;
  logic [`GTU_NUM_TIMERS-1:0] sw_load;
  logic [`GTU_NUM_TIMERS-1:0] hw_load;
  logic [15:0]              hw_val   [`GTU_NUM_TIMERS];
  logic [`GTU_NUM_TIMERS-1:0] base_tick;

  // Events
  logic                     lt1_rise;
  logic                     lt1_fall;
  logic                     lt2_rise;
  logic                     lt2_fall;
  logic                     reload_lower;
  logic                     reload_upper;
  logic                     capture_lower;
  logic                     capture_upper;
  logic                     cap_hit;
  logic [`GTU_NUM_SRC-1:0]  set_evt;
  logic [31:0]              next_rdata;

  // Pin synchroniser
  gtu_sync u_sync (
    .mclk      (mclk),
    .rst       (rst),
    .pin_async (pins),
    .level     (pin_lvl),
    .rise      (pin_rise),
    .fall      (pin_fall)
  );

  // Five timers
  genvar gi;
  generate
    for (gi = 0; gi < `GTU_NUM_TIMERS; gi++) begin : g_tmr
      gtu_timer u_tmr (
        .mclk       (mclk),
        .rst        (rst),
        .tick       (tick[gi]),
        .down       (down[gi]),
        .load       (load[gi]),
        .load_value (load_val[gi]),
        .count      (cnt[gi]),
        .wrap       (wrap[gi])
      );
    end
  endgenerate

  // Free-running prescaler
  always_ff @(posedge mclk) begin
    if (rst) begin
      div <= '0;
    end else begin
      div <= div + 11'h001;
    end
  end

  // Basic mode tick per timer
  always_comb begin
    for (int i = 0; i < `GTU_NUM_TIMERS; i++) begin
      logic pre;
      pre = gtu_pkg::gtu_pre_tick(div, (i < 3) ? `GTU_ONE_MIN_CYC : `GTU_TWO_MIN_CYC,
                                  ctrl[i].prescale);
      case (ctrl[i].mode)
        gtu_pkg::GTU_TIMER: begin
          base_tick[i] = pre;
        end
        gtu_pkg::GTU_GATED: begin
          base_tick[i] = pre & (pin_lvl[i] == ctrl[i].gate_high);
        end
        gtu_pkg::GTU_COUNTER: begin
          base_tick[i] = gtu_pkg::gtu_edge_hit(ctrl[i].edge_sel, pin_rise[i],
                                               pin_fall[i]);
        end
        gtu_pkg::GTU_ROLE: begin
          base_tick[i] = 1'b0;
        end
        default: begin
          base_tick[i] = 1'b0;
        end
      endcase
      down[i] = ctrl[i].down ^ (ctrl[i].ext_dir & pin_lvl[5 + i]);
    end
  end

  // Latch transitions follow core wraps
  assign lt1_rise = wrap[`GTU_CORE_ONE] & ~core_one_toggle_latch;
  assign lt1_fall = wrap[`GTU_CORE_ONE] & core_one_toggle_latch;
  assign lt2_rise = wrap[`GTU_CORE_SECOND] & ~core_two_toggle_latch;
  assign lt2_fall = wrap[`GTU_CORE_SECOND] & core_two_toggle_latch;

  // Core ticks
  assign tick[`GTU_CORE_ONE]    = ctrl[`GTU_CORE_ONE].run & base_tick[`GTU_CORE_ONE];
  assign tick[`GTU_CORE_SECOND] = ctrl[`GTU_CORE_SECOND].run & base_tick[`GTU_CORE_SECOND];

  // Auxiliary ticks, chained to the core latch when selected
  always_comb begin
    tick[`GTU_AUX_LOWER] = ctrl[`GTU_AUX_LOWER].run & base_tick[`GTU_AUX_LOWER];
    if (ctrl[`GTU_AUX_LOWER].chain && ctrl[`GTU_AUX_LOWER].mode != gtu_pkg::GTU_ROLE) begin
      tick[`GTU_AUX_LOWER] = ctrl[`GTU_AUX_LOWER].run &
        gtu_pkg::gtu_edge_hit(ctrl[`GTU_AUX_LOWER].edge_sel, lt1_rise, lt1_fall);
    end
    tick[`GTU_AUX_UPPER] = ctrl[`GTU_AUX_UPPER].run & base_tick[`GTU_AUX_UPPER];
    if (ctrl[`GTU_AUX_UPPER].chain && ctrl[`GTU_AUX_UPPER].mode != gtu_pkg::GTU_ROLE) begin
      tick[`GTU_AUX_UPPER] = ctrl[`GTU_AUX_UPPER].run &
        gtu_pkg::gtu_edge_hit(ctrl[`GTU_AUX_UPPER].edge_sel, lt1_rise, lt1_fall);
    end
    tick[`GTU_AUX_SECOND] = ctrl[`GTU_AUX_SECOND].run & base_tick[`GTU_AUX_SECOND];
    if (ctrl[`GTU_AUX_SECOND].chain) begin
      tick[`GTU_AUX_SECOND] = ctrl[`GTU_AUX_SECOND].run &
        gtu_pkg::gtu_edge_hit(ctrl[`GTU_AUX_SECOND].edge_sel, lt2_rise, lt2_fall);
    end
  end

  // Capture and reload roles of the module one auxiliaries
  always_comb begin
    logic lo_trig;
    logic up_trig;
    lo_trig = ctrl[`GTU_AUX_LOWER].latch_trig ?
      gtu_pkg::gtu_edge_hit(ctrl[`GTU_AUX_LOWER].edge_sel, lt1_rise, lt1_fall) :
      gtu_pkg::gtu_edge_hit(ctrl[`GTU_AUX_LOWER].edge_sel,
                            pin_rise[`GTU_AUX_LOWER], pin_fall[`GTU_AUX_LOWER]);
    up_trig = ctrl[`GTU_AUX_UPPER].latch_trig ?
      gtu_pkg::gtu_edge_hit(ctrl[`GTU_AUX_UPPER].edge_sel, lt1_rise, lt1_fall) :
      gtu_pkg::gtu_edge_hit(ctrl[`GTU_AUX_UPPER].edge_sel,
                            pin_rise[`GTU_AUX_UPPER], pin_fall[`GTU_AUX_UPPER]);
    reload_lower  = (ctrl[`GTU_AUX_LOWER].mode == gtu_pkg::GTU_ROLE) &
                    ctrl[`GTU_AUX_LOWER].reload_role & lo_trig;
    reload_upper  = (ctrl[`GTU_AUX_UPPER].mode == gtu_pkg::GTU_ROLE) &
                    ctrl[`GTU_AUX_UPPER].reload_role & up_trig;
    capture_lower = (ctrl[`GTU_AUX_LOWER].mode == gtu_pkg::GTU_ROLE) &
                    ~ctrl[`GTU_AUX_LOWER].reload_role &
                    gtu_pkg::gtu_edge_hit(ctrl[`GTU_AUX_LOWER].edge_sel,
                      pin_rise[`GTU_AUX_LOWER], pin_fall[`GTU_AUX_LOWER]);
    capture_upper = (ctrl[`GTU_AUX_UPPER].mode == gtu_pkg::GTU_ROLE) &
                    ~ctrl[`GTU_AUX_UPPER].reload_role &
                    gtu_pkg::gtu_edge_hit(ctrl[`GTU_AUX_UPPER].edge_sel,
                      pin_rise[`GTU_AUX_UPPER], pin_fall[`GTU_AUX_UPPER]);
  end

  // Capture/reload register trigger
  assign cap_hit = ctrl[`GTU_CAPTURE_RELOAD_REGISTER].run &
    gtu_pkg::gtu_edge_hit(ctrl[`GTU_CAPTURE_RELOAD_REGISTER].edge_sel, pin_rise[10], pin_fall[10]);

  // Hardware loads
  always_comb begin
    for (int i = 0; i < `GTU_NUM_TIMERS; i++) begin
      hw_load[i] = 1'b0;
      hw_val[i]  = cnt[`GTU_CORE_ONE];
    end
    hw_load[`GTU_AUX_LOWER] = capture_lower;
    hw_load[`GTU_AUX_UPPER] = capture_upper;
    // Lower reloads win if both fire at once
    if (reload_lower) begin
      hw_load[`GTU_CORE_ONE] = 1'b1;
      hw_val[`GTU_CORE_ONE]  = cnt[`GTU_AUX_LOWER];
    end else if (reload_upper) begin
      hw_load[`GTU_CORE_ONE] = 1'b1;
      hw_val[`GTU_CORE_ONE]  = cnt[`GTU_AUX_UPPER];
    end
    hw_load[`GTU_AUX_SECOND] = cap_hit & ctrl[`GTU_CAPTURE_RELOAD_REGISTER].opt;
    hw_val[`GTU_AUX_SECOND]  = 16'h0000;
    hw_load[`GTU_CORE_SECOND] = ctrl[`GTU_CORE_SECOND].opt & wrap[`GTU_CORE_SECOND];
    hw_val[`GTU_CORE_SECOND]  = capture_reload_register;
  end

  // Software count writes take priority over hardware loads
  always_comb begin
    for (int i = 0; i < `GTU_NUM_TIMERS; i++) begin
      sw_load[i]  = wr_pend && (wr_addr == `GTU_ADDR_COUNT_BASE + 8'(i * 4));
      load[i]     = sw_load[i] | hw_load[i];
      load_val[i] = sw_load[i] ? hwdata[15:0] : hw_val[i];
    end
  end

  // Toggle latches
  always_ff @(posedge mclk) begin
    if (rst) begin
      core_one_toggle_latch <= 1'b0;
      core_two_toggle_latch <= 1'b0;
    end else begin
      core_one_toggle_latch <= core_one_toggle_latch ^ wrap[`GTU_CORE_ONE];
      core_two_toggle_latch <= core_two_toggle_latch ^ wrap[`GTU_CORE_SECOND];
    end
  end

  // Toggle pins
  always_ff @(posedge mclk) begin
    if (rst) begin
      core_one_toggle_pin <= 1'b0;
      core_two_toggle_pin <= 1'b0;
    end else begin
      core_one_toggle_pin <= core_one_toggle_latch & ctrl[`GTU_CORE_ONE].pin_out;
      core_two_toggle_pin <= core_two_toggle_latch & ctrl[`GTU_CORE_SECOND].pin_out;
    end
  end

  // Capture/reload register
  always_ff @(posedge mclk) begin
    if (rst) begin
      capture_reload_register <= `GTU_COUNT_RESET;
    end else if (wr_pend && wr_addr == `GTU_ADDR_CAPTURE_RELOAD_REGISTER) begin
      capture_reload_register <= hwdata[15:0];
    end else if (cap_hit) begin
      capture_reload_register <= cnt[`GTU_AUX_SECOND];
    end
  end

  // Request events
  assign set_evt[`GTU_AUX_LOWER]   = wrap[`GTU_AUX_LOWER] | capture_lower;
  assign set_evt[`GTU_CORE_ONE]    = wrap[`GTU_CORE_ONE];
  assign set_evt[`GTU_AUX_UPPER]   = wrap[`GTU_AUX_UPPER] | capture_upper;
  assign set_evt[`GTU_AUX_SECOND]  = wrap[`GTU_AUX_SECOND];
  assign set_evt[`GTU_CORE_SECOND] = wrap[`GTU_CORE_SECOND];
  assign set_evt[`GTU_CAPTURE_RELOAD_REGISTER]      = cap_hit;

  // Control registers; a hardware set beats a software clear
  always_ff @(posedge mclk) begin
    for (int i = 0; i < `GTU_NUM_SRC; i++) begin
      if (rst) begin
        ctrl[i] <= `GTU_CTRL_RESET;
      end else begin
        if (wr_pend && wr_addr == `GTU_ADDR_CTRL_BASE + 8'(i * 4)) begin
          ctrl[i] <= hwdata & `GTU_CTRL_MASK;
        end
        if (set_evt[i]) begin
          ctrl[i].req <= 1'b1;
        end
      end
    end
  end

  // Pending requests
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_pending <= '0;
    end else begin
      for (int i = 0; i < `GTU_NUM_SRC; i++) begin
        irq_pending[i] <= ctrl[i].req & ctrl[i].en;
      end
    end
  end

  // AHB-Lite address phase
  assign ap_take   = hsel & hready & htrans[1];
  assign addr_ok   = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= ap_take & hwrite & addr_ok;
      wr_addr <= haddr[7:0];
    end
  end

  // Read mux
  always_comb begin
    next_rdata = 32'h00000000;
    for (int i = 0; i < `GTU_NUM_SRC; i++) begin
      if (haddr[7:0] == `GTU_ADDR_CTRL_BASE + 8'(i * 4)) begin
        next_rdata = ctrl[i];
      end
    end
    for (int i = 0; i < `GTU_NUM_TIMERS; i++) begin
      if (haddr[7:0] == `GTU_ADDR_COUNT_BASE + 8'(i * 4)) begin
        next_rdata = {16'h0000, cnt[i]};
      end
    end
    if (haddr[7:0] == `GTU_ADDR_CAPTURE_RELOAD_REGISTER) begin
      next_rdata = {16'h0000, capture_reload_register};
    end
    if (!addr_ok) begin
      next_rdata = 32'h00000000;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (ap_take && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

endmodule : gtu_unit

//--- gtu_unit_sva.sv
// Port checker for the general purpose timer unit
`timescale 1ns/1ps
module gtu_unit_sva (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        core_one_toggle_pin,
  input wire logic        core_two_toggle_pin,
  input wire logic [5:0]  irq_pending
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  logic rd_ph;
  assign rd_ph = hsel && hready && htrans[1] && !hwrite;

  reset_clear_a: assert property (
    $fell(rst) |-> irq_pending == 6'h00 && !core_one_toggle_pin && !core_two_toggle_pin)
    else $error("state not cleared by reset");
  data_hold_a: assert property (
    !rd_ph |=> $stable(hrdata)) else $error("read data changed without a read");
  unmapped_zero_a: assert property (
    rd_ph && haddr[31:8] != 24'h000000 |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  count_width_a: assert property (
    rd_ph && haddr >= 32'h00000020 && haddr <= 32'h00000034 |=> hrdata[31:16] == 16'h0000)
    else $error("count read wider than 16 bits");
  ctrl_width_a: assert property (
    rd_ph && haddr <= 32'h00000014 |=> hrdata[31:22] == 10'h000)
    else $error("control read sets reserved bits");
  one_rate_a: assert property (
    $changed(core_one_toggle_pin) |=> $stable(core_one_toggle_pin) [*7])
    else $error("module one toggles faster than eight clocks");
  two_rate_a: assert property (
    $changed(core_two_toggle_pin) |=> $stable(core_two_toggle_pin) [*3])
    else $error("module two toggles faster than four clocks");
  bus_okay_a: assert property (
    hreadyout == 1'b1 && hresp == 1'b0) else $error("bus answer not ready and okay");

  cover property ($rose(core_one_toggle_pin));
  cover property ($rose(core_two_toggle_pin));
  cover property ($rose(irq_pending[5]));
endmodule : gtu_unit_sva

bind gtu_unit gtu_unit_sva u_sva (
  .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .core_one_toggle_pin(core_one_toggle_pin),
  .core_two_toggle_pin(core_two_toggle_pin), .irq_pending(irq_pending)
);

//--- gtu_pin_model.sv
// Model of the external gate, count, direction and capture pins
`timescale 1ns/1ps
module gtu_pin_model (
  input  wire logic         mclk,
  output gtu_pkg::gtu_pins_t pins
);
  initial pins = '0;
  // Count and capture edges, each level held four clocks
  task automatic pulse(input int idx, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge mclk);
      pins[idx] <= 1'b1;
      repeat (4) @(posedge mclk);
      pins[idx] <= 1'b0;
    end
  endtask : pulse
  // Gate and direction levels
  task automatic level(input int idx, input logic v);
    @(posedge mclk);
    pins[idx] <= v;
  endtask : level
endmodule : gtu_pin_model

//--- gtu_unit_tb.sv
// Self-checking testbench for the general purpose timer unit
`timescale 1ns/1ps
module gtu_unit_tb;
  typedef struct {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] exp_v;
  } gtu_row_t;
  logic               mclk;
  logic               rst;
  logic               hsel;
  logic [31:0]        haddr;
  logic [1:0]         htrans;
  logic               hwrite;
  logic [31:0]        hwdata;
  logic               hreadyout;
  logic [31:0]        hrdata;
  logic               hresp;
  gtu_pkg::gtu_pins_t pins;
  logic               tog_one;
  logic               tog_two;
  logic [5:0]         irq_pending;
  logic [7:0]         obs;
  logic [31:0]        rv;
  logic [31:0]        cap;
  int                 n_mismatch;
  int                 n_compared;
  gtu_row_t           rows [6];

  assign obs = {irq_pending, tog_two, tog_one};
  gtu_pin_model u_pins (.mclk(mclk), .pins(pins));
  gtu_unit uut (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pins(pins),
    .core_one_toggle_pin(tog_one), .core_two_toggle_pin(tog_two),
    .irq_pending(irq_pending)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic complete_run;
    $display("mismatches %0d of %0d compared", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp_v);
    n_compared++;
    if (seen !== exp_v) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp_v);
    end
  endtask : check

  task automatic wait_bit(input int idx, input int limit);
    int i;
    i = 0;
    while (obs[idx] !== 1'b1) begin
      @(posedge mclk);
      i++;
      if (i > limit) begin
        n_mismatch++;
        complete_run();
      end
    end
  endtask : wait_bit

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_ready;
    int i;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (hreadyout !== 1'b1 && i <= 20);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rv = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [31:0] a);
    bus(1'b0, a, 32'h00000000);
  endtask : rd

  initial begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    n_mismatch = 0;
    n_compared = 0;
    rows = '{'{32'h20, 32'hdead1234, 32'h00001234},
             '{32'h30, 32'hffffabcd, 32'h0000abcd},
             '{32'h34, 32'h00005a5a, 32'h00005a5a},
             '{32'h0c, 32'hffcf0000, 32'h000f0000},
             '{32'h40, 32'h12345678, 32'h00000000},
             '{32'h104, 32'h00000900, 32'h00000000}};
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      rd(32'(i * 4));
      check(rv, 32'h0);
    end
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr);
      check(rv, rows[i].exp_v);
    end
    // Core one timer mode: wrap, toggle pin, request, count rate
    wr(32'h24, 32'h0000fffe);
    wr(32'h04, 32'h00100900);
    wait_bit(0, 40);
    check({31'h0, irq_pending[1]}, 32'h1);
    rd(32'h24);
    cap = rv;
    repeat (77) @(posedge mclk);
    rd(32'h24);
    check(rv - cap, 32'h0000000a);
    // Lower aux counter mode, down, then reversed by direction pin
    wr(32'h20, 32'h0);
    wr(32'h00, 32'h00100758);
    u_pins.pulse(0, 3);
    repeat (8) @(posedge mclk);
    rd(32'h20);
    check(rv, 32'h0000fffd);
    check({31'h0, irq_pending[0]}, 32'h1);
    u_pins.level(5, 1'b1);
    u_pins.pulse(0, 3);
    repeat (8) @(posedge mclk);
    rd(32'h20);
    check(rv, 32'h0);
    // Upper aux gated mode
    wr(32'h08, 32'h00000128);
    repeat (80) @(posedge mclk);
    rd(32'h28);
    check(rv, 32'h0);
    u_pins.level(2, 1'b1);
    repeat (80) @(posedge mclk);
    rd(32'h28);
    check({31'h0, rv != 32'h0}, 32'h1);
    // Capture of second aux with clear
    wr(32'h0c, 32'h00000100);
    wr(32'h14, 32'h00108140);
    repeat (60) @(posedge mclk);
    u_pins.pulse(10, 1);
    repeat (8) @(posedge mclk);
    rd(32'h34);
    cap = rv;
    check({31'h0, cap >= 32'd14 && cap <= 32'd24}, 32'h1);
    rd(32'h2c);
    check({31'h0, rv < cap}, 32'h1);
    check({31'h0, irq_pending[5]}, 32'h1);
    // Core two wraps, toggles pin, reloads from capture register
    wr(32'h30, 32'h0000fffe);
    wr(32'h10, 32'h00008900);
    wait_bit(1, 30);
    rd(32'h30);
    check({31'h0, rv >= cap && rv < cap + 32'd8}, 32'h1);
    // Reset in mid-run clears counts and pins
    @(posedge mclk);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd(32'h24);
    check(rv, 32'h0);
    check({30'h0, tog_two, tog_one}, 32'h0);
    complete_run();
  end
endmodule : gtu_unit_tb
